// *** core/sleep_wakeup_controller.sv ***
// Sleep, wake-up and reset sequencing for the system basis chip.
// Assumes the SPI front end decodes registers into the plain ports below.
// What this block does
// - Forced wake bit: timed wake from sleep, with reset
// - No configuration within 75 ms: back to sleep
// - Cyclic sense overrides forced wake
// - Eight periods from 32 ms to 8192 ms
// - Three wake inputs in normal, standby, sleep
// - Switched-supply inputs count only with supply on
// - No-wake option ignores inputs
// - High option: wake after over 20 us high
// - Low option: wake after over 20 us low
// - Change option: reference when programmed, wake on lasting change
// - Sampled rise: low,low,high,high; fall the opposite
// - Both edges: two samples one level, two the other
// - Cyclic sensing only in sleep
// - Supply on 400 us per period, sampled at 300 us
// - Sleep: permanent sense for battery-fed inputs only
// - Normal, standby: live levels, flags, maskable interrupt
// - Sleep wake: flag, normal request with reset
// - Chip-select fall, regulator off: wake, set flag
// - Interrupt masked per source
// - Reset pulse lasts 1 ms
// - Host reset release: normal request
// - Flags clear on read; pending flags block sleep
`timescale 1ns/100ps
module sleep_wakeup_controller
   import wake_pkg::*;
#(
   parameter int MS_CYCLES = MS_CYC,
   parameter int TIMEOUT_CYCLES = TIMEOUT_CYC,
   parameter int RESET_CYCLES = RESET_CYC,
   parameter int FILT_CYCLES = FILTER_CYC
) (
   // Clock and reset
   input wire logic clk,
   input wire logic resetn,
   // Switched supply control
   input wire logic timedForcedWake,
   input wire logic cyclicSenseEn,
   input wire logic inputsOnSwitchedSupply,
   input wire logic switchedOnReq,
   input wire logic [2:0] cyclicTimingControl,
   // Wake input control, one option and arm strobe per input
   input wire logic [8:0] wakeInputControl,
   input wire logic [2:0] wakeOptionWrite,
   input wire logic wakeStatusRead,
   input wire logic intStatusSecondRead,
   // Mode commands, checked here against verification register
   input wire logic [2:0] modeControl,
   input wire logic [2:0] modeControlVerify,
   input wire logic modeWrite,
   input wire logic swConfigured,
   // Interrupt sources and masks
   input wire logic [IRQ_NUM-1:0] irqSources,
   input wire logic [IRQ_NUM-1:0] irqMask,
   // Pins
   input wire logic [2:0] localWakeInputs,
   input wire logic chipSelectN,
   input wire logic mainRegulatorOff,
   input wire logic resetPinIn,
   // Outputs
   output logic resetPinOut,
   output logic resetPinOe,
   output logic mainRegulatorOn,
   output logic switchedBatteryOutput,
   output logic intN,
   output logic [2:0] wakeInputLiveLevel,
   output logic [2:0] wakeInputStatus,
   output logic spiWakeFlag,
   output logic [2:0] modeState
);

   localparam logic [2:0] MODE_SLEEP = 3'h4;
   localparam logic [2:0] MODE_NORMAL = 3'h1;
   localparam logic [2:0] MODE_STANDBY = 3'h2;

   if (MS_CYCLES < 1 || RESET_CYCLES < 1 || TIMEOUT_CYCLES < 1) begin
      $error("timing counts below one cycle");
   end

   ////////////////////////////////////////////////////////////////////
   // Pin synchronisers, two flops each
   logic [5:0] syncA_r, syncB_r;
   logic [2:0] lvl;
   logic csN, rstIn, regOff;
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         syncA_r <= 6'h3f;
         syncB_r <= 6'h3f;
      end else begin
         syncA_r <= {mainRegulatorOff, resetPinIn, chipSelectN,
            localWakeInputs};
         syncB_r <= syncA_r;
      end
   end
   assign lvl = syncB_r[2:0];
   assign csN = syncB_r[3];
   assign rstIn = syncB_r[4];
   assign regOff = syncB_r[5];

   ////////////////////////////////////////////////////////////////////
   // Mode, timers and reset pulse
   mode_e mode_r, mode_nxt;
   logic [31:0] msCnt_r, msCnt_nxt;
   logic [13:0] msTick_r, msTick_nxt;
   logic [31:0] tmo_r, tmo_nxt;
   logic [31:0] rstCnt_r, rstCnt_nxt;
   logic [15:0] senseCnt_r, senseCnt_nxt;
   logic csPrev_r, csPrev_nxt;
   logic rstPrev_r, rstPrev_nxt;
   logic [2:0] status_r, status_nxt;
   logic spiFlag_r, spiFlag_nxt;
   logic senseOn_r, senseOn_nxt;
   logic sampleNow;
   logic periodEnd;
   logic [2:0] wakeHit;
   logic localWake;
   logic sleeping;
   logic awake;
   logic modeOk;
   logic cyclicActive;
   logic forcedActive;
   logic sleepReq;

   assign sleeping = (mode_r == ST_SLEEP);
   assign awake = (mode_r == ST_NORMAL) || (mode_r == ST_STANDBY);
   assign cyclicActive = sleeping && cyclicSenseEn;
   assign forcedActive = sleeping && timedForcedWake && !cyclicSenseEn;
   assign periodEnd = (msTick_r == period_ms(cyclicTimingControl) - 14'h1)
      && (msCnt_r == 32'(MS_CYCLES - 1));
   assign sampleNow = cyclicActive && senseOn_r
      && (senseCnt_r == 16'(SAMPLE_AT_CYC));
   assign localWake = |wakeHit;
   assign modeOk = modeWrite && (modeControl == modeControlVerify);
   assign sleepReq = modeOk && (modeControl == MODE_SLEEP)
      && (status_r == 3'h0) && !spiFlag_r;

   // Wake filters, one per input
   genvar gi;
   for (gi = 0; gi < NUM_INPUTS; gi++) begin : g_in
      wake_filter_if fbus();
      assign fbus.level = lvl[gi];
      assign fbus.option = wakeInputControl[3*gi +: 3];
      assign fbus.arm = wakeOptionWrite[gi];
      assign fbus.cyclic = cyclicActive && inputsOnSwitchedSupply;
      assign fbus.sampleStrobe = sampleNow;
      // Switched-supply inputs only count while that supply is on
      assign fbus.enable = (awake || sleeping)
         && (!inputsOnSwitchedSupply || switchedBatteryOutput)
         && (!sleeping || !inputsOnSwitchedSupply || cyclicSenseEn);
      assign wakeHit[gi] = fbus.wake;
      wake_input_filter #(.FILT_CYC(FILT_CYCLES)) u_filt (
         .clk(clk),
         .resetn(resetn),
         .bus(fbus)
      );
   end

   // Next-state logic for mode and timers
   always_comb begin
      mode_nxt = mode_r;
      msCnt_nxt = msCnt_r;
      msTick_nxt = msTick_r;
      tmo_nxt = tmo_r;
      rstCnt_nxt = rstCnt_r;
      senseCnt_nxt = senseCnt_r;
      senseOn_nxt = senseOn_r;
      csPrev_nxt = csN;
      rstPrev_nxt = rstIn;
      // Set wins over the read-clear
      status_nxt = (wakeStatusRead ? 3'h0 : status_r) | wakeHit;
      spiFlag_nxt = intStatusSecondRead ? 1'b0 : spiFlag_r;
      // Millisecond base only runs in sleep
      if (sleeping) begin
         if (msCnt_r == 32'(MS_CYCLES - 1)) begin
            msCnt_nxt = 32'h0;
            msTick_nxt = periodEnd ? 14'h0 : msTick_r + 14'h1;
         end else begin
            msCnt_nxt = msCnt_r + 32'h1;
         end
      end else begin
         msCnt_nxt = 32'h0;
         msTick_nxt = 14'h0;
      end
      // Supply on window per cyclic period
      if (cyclicActive && periodEnd) begin
         senseOn_nxt = 1'b1;
         senseCnt_nxt = 16'h0;
      end else if (senseOn_r) begin
         if (!cyclicActive || senseCnt_r == 16'(SENSE_ON_CYC - 1))
            senseOn_nxt = 1'b0;
         senseCnt_nxt = senseCnt_r + 16'h1;
      end
      case (mode_r)
         ST_RESET: begin
            // Fixed-length pulse, then release
            if (rstCnt_r == 32'(RESET_CYCLES - 1)) begin
               mode_nxt = ST_NORMAL_REQ;
               tmo_nxt = 32'h0;
            end else begin
               rstCnt_nxt = rstCnt_r + 32'h1;
            end
         end
         ST_NORMAL_REQ: begin
            if (swConfigured) begin
               mode_nxt = ST_NORMAL;
            end else if (tmo_r == 32'(TIMEOUT_CYCLES - 1)) begin
               mode_nxt = ST_SLEEP;
            end else begin
               tmo_nxt = tmo_r + 32'h1;
            end
         end
         ST_NORMAL, ST_STANDBY: begin
            if (sleepReq) mode_nxt = ST_SLEEP;
            else if (modeOk && modeControl == MODE_STANDBY)
               mode_nxt = ST_STANDBY;
            else if (modeOk && modeControl == MODE_NORMAL)
               mode_nxt = ST_NORMAL;
         end
         ST_SLEEP: begin
            if (localWake || (forcedActive && periodEnd)) begin
               mode_nxt = ST_RESET;
               rstCnt_nxt = 32'h0;
            end else if (regOff && csPrev_r && !csN) begin
               mode_nxt = ST_RESET;
               rstCnt_nxt = 32'h0;
               spiFlag_nxt = 1'b1;
            end
         end
         default: mode_nxt = ST_RESET;
      endcase
      // Host release; our own release seen in normal request is no event
      if (awake && !rstPrev_r && rstIn) begin
         mode_nxt = ST_NORMAL_REQ;
         tmo_nxt = 32'h0;
      end
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         mode_r <= ST_RESET;
         msCnt_r <= 32'h0;
         msTick_r <= 14'h0;
         tmo_r <= 32'h0;
         rstCnt_r <= 32'h0;
         senseCnt_r <= 16'h0;
         senseOn_r <= 1'b0;
         csPrev_r <= 1'b1;
         rstPrev_r <= 1'b1;
         status_r <= 3'h0;
         spiFlag_r <= 1'b0;
      end else begin
         mode_r <= mode_nxt;
         msCnt_r <= msCnt_nxt;
         msTick_r <= msTick_nxt;
         tmo_r <= tmo_nxt;
         rstCnt_r <= rstCnt_nxt;
         senseCnt_r <= senseCnt_nxt;
         senseOn_r <= senseOn_nxt;
         csPrev_r <= csPrev_nxt;
         rstPrev_r <= rstPrev_nxt;
         status_r <= status_nxt;
         spiFlag_r <= spiFlag_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Registered outputs
   logic intN_r, intN_nxt;
   logic [2:0] live_r, live_nxt;
   logic [2:0] modeOut_r, modeOut_nxt;
   logic [IRQ_NUM-1:0] src;

   always_comb begin
      src = irqSources;
      src[IRQ_LOCAL] = src[IRQ_LOCAL] | (|status_r);
      src[IRQ_BUS] = src[IRQ_BUS] | spiFlag_r;
      // Interrupt only in normal and standby; each source masked
      intN_nxt = !(awake && |(src & irqMask));
      live_nxt = awake ? lvl : live_r;
      case (mode_r)
         ST_RESET: modeOut_nxt = 3'h0;
         ST_NORMAL_REQ: modeOut_nxt = 3'h3;
         ST_NORMAL: modeOut_nxt = MODE_NORMAL;
         ST_STANDBY: modeOut_nxt = MODE_STANDBY;
         ST_SLEEP: modeOut_nxt = MODE_SLEEP;
         default: modeOut_nxt = 3'h0;
      endcase
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         intN_r <= 1'b1;
         live_r <= 3'h0;
         modeOut_r <= 3'h0;
      end else begin
         intN_r <= intN_nxt;
         live_r <= live_nxt;
         modeOut_r <= modeOut_nxt;
      end
   end

   // Reset pin driven low in reset and sleep, released otherwise
   assign resetPinOut = 1'b0;
   assign resetPinOe = (mode_r == ST_RESET) || sleeping;
   assign mainRegulatorOn = !sleeping;
   assign switchedBatteryOutput = sleeping
      ? (cyclicActive && senseOn_r) : switchedOnReq;
   assign intN = intN_r;
   assign wakeInputLiveLevel = live_r;
   assign wakeInputStatus = status_r;
   assign spiWakeFlag = spiFlag_r;
   assign modeState = modeOut_r;

endmodule

// *** core/wake_pkg.sv ***
// Shared constants and types of the sleep and wake-up controller.
// Assumes a 25 MHz internal clock; counts are derived from that rate.
package wake_pkg;

   localparam int CLK_HZ = 25000000;
   localparam int FILTER_US = 20;
   localparam int SENSE_ON_US = 400;
   localparam int SAMPLE_AT_US = 300;
   localparam int CONFIG_TIMEOUT_MS = 75;
   localparam int RESET_PULSE_MS = 1;
   localparam int US_CYC = CLK_HZ / 1000000;
   localparam int MS_CYC = CLK_HZ / 1000;
   localparam int FILTER_CYC = FILTER_US * US_CYC;
   localparam int SENSE_ON_CYC = SENSE_ON_US * US_CYC;
   localparam int SAMPLE_AT_CYC = SAMPLE_AT_US * US_CYC;
   localparam int TIMEOUT_CYC = CONFIG_TIMEOUT_MS * MS_CYC;
   localparam int RESET_CYC = RESET_PULSE_MS * MS_CYC;
   localparam int NUM_INPUTS = 3;

   // Wake input option codes
   localparam logic [2:0] OPT_NONE = 3'h0;
   localparam logic [2:0] OPT_HIGH = 3'h1;
   localparam logic [2:0] OPT_LOW = 3'h2;
   localparam logic [2:0] OPT_CHANGE = 3'h3;
   localparam logic [2:0] OPT_RISE = 3'h4;
   localparam logic [2:0] OPT_FALL = 3'h5;
   localparam logic [2:0] OPT_BOTH = 3'h6;

   // Interrupt source bit positions
   localparam int IRQ_NUM = 8;
   localparam int IRQ_LOCAL = 6;
   localparam int IRQ_BUS = 7;

   typedef enum {
      ST_RESET,
      ST_NORMAL_REQ,
      ST_NORMAL,
      ST_STANDBY,
      ST_SLEEP
   } mode_e;

   // Period selection in milliseconds: 32 ms up to 8192 ms
   function automatic logic [13:0] period_ms(input logic [2:0] sel);
      // Doubling steps; the last code jumps to 8192
      period_ms = (sel == 3'h7) ? 14'h2000 : 14'h0020 << sel;
   endfunction

endpackage

// *** core/wake_filter_if.sv ***
// Carries one wake input's filter controls and results.
// Assumes both ends run on the controller clock.
`timescale 1ns/100ps
interface wake_filter_if;
   logic level;
   logic [2:0] option;
   logic arm;
   logic enable;
   logic sampleStrobe;
   logic cyclic;
   logic wake;

   modport ctrl (output level, option, arm, enable, sampleStrobe, cyclic,
      input wake);
   modport filt (input level, option, arm, enable, sampleStrobe, cyclic,
      output wake);
endinterface

// *** core/wake_input_filter.sv ***
// Wake detection for one local input: level, change and sampled edges.
// Assumes level is already synchronised to clk.
`timescale 1ns/100ps
module wake_input_filter
   import wake_pkg::*;
#(
   parameter int FILT_CYC = FILTER_CYC
) (
   // Clock and reset
   input wire logic clk,
   input wire logic resetn,
   // Filter controls
   wake_filter_if.filt bus
);

   if (FILT_CYC < 1 || FILT_CYC > 65535) begin
      $error("filter length out of range");
   end

   logic [15:0] cnt_r, cnt_nxt;
   logic ref_r, ref_nxt;
   logic [3:0] hist_r, hist_nxt;
   logic wake_r, wake_nxt;
   logic prev_r, prev_nxt;
   logic target;

   assign bus.wake = wake_r;

   ////////////////////////////////////////////////////////////////////
   // Filter counter restarts whenever the level leaves the target
   always_comb begin
      cnt_nxt = cnt_r;
      ref_nxt = ref_r;
      hist_nxt = hist_r;
      wake_nxt = 1'b0;
      prev_nxt = bus.level;
      target = 1'b0;
      case (bus.option)
         OPT_HIGH: target = bus.level;
         OPT_LOW: target = ~bus.level;
         OPT_CHANGE: target = bus.level ^ ref_r;
         default: target = 1'b0;
      endcase
      if (bus.arm) begin
         ref_nxt = bus.level;
         hist_nxt = 4'h0;
         cnt_nxt = 16'h0;
      end else if (!bus.enable) begin
         cnt_nxt = 16'h0;
      end else if (bus.cyclic) begin
         cnt_nxt = 16'h0;
         // Four-sample history, oldest in the top bit
         if (bus.sampleStrobe) begin
            hist_nxt = {hist_r[2:0], bus.level};
            case (bus.option)
               OPT_RISE: wake_nxt = (hist_nxt == 4'h3);
               OPT_FALL: wake_nxt = (hist_nxt == 4'hc);
               OPT_BOTH: wake_nxt = (hist_nxt == 4'h3)
                  | (hist_nxt == 4'hc);
               default: wake_nxt = 1'b0;
            endcase
         end
      end else if (!target || (bus.level != prev_r)) begin
         cnt_nxt = 16'h0;
      end else if (cnt_r == 16'(FILT_CYC)) begin
         // Filter time passed: fire, rearm change ref
         wake_nxt = 1'b1;
         cnt_nxt = 16'h0;
         if (bus.option == OPT_CHANGE) ref_nxt = bus.level;
      end else begin
         cnt_nxt = cnt_r + 16'h1;
      end
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         cnt_r <= 16'h0;
         ref_r <= 1'b0;
         hist_r <= 4'h0;
         wake_r <= 1'b0;
         prev_r <= 1'b0;
      end else begin
         cnt_r <= cnt_nxt;
         ref_r <= ref_nxt;
         hist_r <= hist_nxt;
         wake_r <= wake_nxt;
         prev_r <= prev_nxt;
      end
   end

endmodule

// *** verif/mcu_model.sv ***
// Microcontroller model: owns the reset pin wire, chip select, config.
// Assumes resetPinOe drives the reset pin low.
`timescale 1ns/100ps
module mcu_model (
   // Clock
   input wire logic clk,
   // Device side of the reset pin
   input wire logic resetPinOe,
   input wire logic resetPinOut,
   // Bench controls
   input wire logic autoCfg,
   input wire logic pullLow,
   input wire logic csFall,
   // Toward the device
   output logic resetPinIn,
   output logic chipSelectN,
   output logic swConfigured
);
   int cnt;

   ////////////////////////////////////////////////////////////////////////
   // Pull-up wins only when no party drives the pin low
   assign resetPinIn = !((resetPinOe && !resetPinOut) || pullLow);

   initial begin
      cnt = 9;
      swConfigured = 1'b0;
      chipSelectN = 1'b1;
   end

   // Configure a while after release, so the device has left reset
   always @(posedge clk) begin
      swConfigured <= 1'b0;
      if (!resetPinIn)
         cnt <= 0;
      else if (cnt < 9)
         cnt <= cnt + 1;
      if (cnt == 8 && autoCfg)
         swConfigured <= 1'b1;
      chipSelectN <= !csFall;
   end
endmodule

// *** verif/sleep_wakeup_controller_asserts.sv ***
// Concurrent checks on the sleep and wake-up controller ports.
// Assumes one clock domain.
`timescale 1ns/100ps
module sleep_wakeup_controller_asserts #(
   parameter int RESET_CYCLES = 5,
   parameter int TIMEOUT_CYCLES = 50
) (
   // Clock and reset
   input wire logic clk,
   input wire logic resetn,
   // Watched inputs
   input wire logic switchedOnReq,
   input wire logic wakeStatusRead,
   input wire logic intStatusSecondRead,
   input wire logic [2:0] modeControl,
   input wire logic [2:0] modeControlVerify,
   input wire logic modeWrite,
   input wire logic [7:0] irqSources,
   input wire logic [7:0] irqMask,
   // Watched outputs
   input wire logic resetPinOe,
   input wire logic mainRegulatorOn,
   input wire logic switchedBatteryOutput,
   input wire logic intN,
   input wire logic [2:0] wakeInputStatus,
   input wire logic spiWakeFlag,
   input wire logic [2:0] modeState
);
   int rstCnt_r, rstCnt_nxt, nrCnt_r, nrCnt_nxt;
   logic sleepCmd;

   default clocking cb @(posedge clk); endclocking
   default disable iff (!resetn);

   ////////////////////////////////////////////////////////////////////////
   // Cycles spent in reset and in normal request
   always_comb begin
      rstCnt_nxt = (modeState == 3'h0) ? rstCnt_r + 1 : 0;
      nrCnt_nxt = (modeState == 3'h3) ? nrCnt_r + 1 : 0;
      sleepCmd = modeWrite && modeControl == 3'h4;
      sleepCmd = sleepCmd && modeControlVerify == 3'h4;
   end

   // Registered counters, cleared by reset
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         rstCnt_r <= 0;
         nrCnt_r <= 0;
      end else begin
         rstCnt_r <= rstCnt_nxt;
         nrCnt_r <= nrCnt_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   a_pin_low_state: assert property (
      $past(resetPinOe) == (modeState == 3'h0 || modeState == 3'h4))
      else $error("reset pin drive off mode");
   a_pulse_length: assert property (
      ($past(modeState) == 3'h0 && modeState != 3'h0) |->
      rstCnt_r inside {[RESET_CYCLES - 1 : RESET_CYCLES + 2]})
      else $error("reset pulse length wrong");
   a_regulator_mode: assert property (
      $past(mainRegulatorOn) == (modeState != 3'h4))
      else $error("regulator off mode");
   a_config_timeout: assert property (
      modeState == 3'h3 |-> nrCnt_r <= TIMEOUT_CYCLES + 2)
      else $error("normal request too long");
   a_sense_only_sleep: assert property (
      (modeState != 3'h4 && $past(modeState) != 3'h4 &&
      !switchedOnReq && !$past(switchedOnReq)) |-> !switchedBatteryOutput)
      else $error("switched supply on outside sleep");
   a_status_sticky: assert property (
      |($past(wakeInputStatus) & ~wakeInputStatus) |-> $past(wakeStatusRead))
      else $error("status fell without read");
   a_spi_sticky: assert property (
      $fell(spiWakeFlag) |-> $past(intStatusSecondRead))
      else $error("spi wake flag fell without read");
   a_int_masked: assert property (
      ($past(irqSources & irqMask) == 8'h00 && $past(irqMask[7:6]) == 2'h0)
      |-> intN)
      else $error("interrupt while masked");
   a_sleep_refused: assert property (
      (sleepCmd && modeState inside {3'h1, 3'h2}
      && (|wakeInputStatus || spiWakeFlag)) |-> ##2 modeState != 3'h4)
      else $error("sleep with pending flag");
   a_sleep_code: assert property (
      ($past(modeState) inside {3'h1, 3'h2} && modeState == 3'h4) |->
      $past(sleepCmd, 2))
      else $error("sleep without sleep code");

   c_sleep: cover property (modeState == 3'h4);
   c_forced: cover property ($past(modeState) == 3'h4 && modeState == 3'h0);
   c_spi: cover property ($rose(spiWakeFlag));
   c_status: cover property ($rose(|wakeInputStatus));
endmodule

bind sleep_wakeup_controller sleep_wakeup_controller_asserts #(
   .RESET_CYCLES(RESET_CYCLES), .TIMEOUT_CYCLES(TIMEOUT_CYCLES)) i_chk (.*);

// *** verif/sleep_wakeup_controller_bench.sv ***
// Self-checking bench of the sleep and wake-up controller.
// Assumes the host model and the bound checker.
`timescale 1ns/100ps
module sleep_wakeup_controller_bench;
   import wake_pkg::*;
   localparam int RST_C = 5;
   localparam int TO_C = 50;
   localparam int MS_C = 5;
   localparam int FI_C = 3;
   localparam int PER[8] = '{32, 64, 128, 256, 512, 1024, 2048, 8192};
   logic clk, resetn, timedForcedWake, cyclicSenseEn, switchedOnReq;
   logic inputsOnSwitchedSupply, wakeStatusRead, intStatusSecondRead;
   logic [2:0] cyclicTimingControl, wakeOptionWrite, modeControl;
   logic [2:0] modeControlVerify, localWakeInputs;
   logic [8:0] wakeInputControl;
   logic [IRQ_NUM-1:0] irqSources, irqMask;
   logic modeWrite, mainRegulatorOff, autoCfg, pullLow, csFall;
   logic chipSelectN, swConfigured, resetPinIn, resetPinOut, resetPinOe;
   logic mainRegulatorOn, switchedBatteryOutput, intN, spiWakeFlag;
   logic [2:0] wakeInputLiveLevel, wakeInputStatus, modeState;
   int nFail, compares, n;

   sleep_wakeup_controller #(.MS_CYCLES(MS_C), .TIMEOUT_CYCLES(TO_C),
      .RESET_CYCLES(RST_C), .FILT_CYCLES(FI_C)) i_dut (.*);
   mcu_model i_mcu (.*);

   ////////////////////////////////////////////////////////////////////////
   // Free-running 25 MHz clock
   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end

   // Watchdog above the forced wake run
   initial begin
      #(40 * 95000);
      nFail++;
      wrapUp();
   end

   task automatic check(input logic [7:0] seen, input logic [7:0] exp,
      input string msg);
      compares++;
      if (seen !== exp) begin
         nFail++;
         $display("CHECK FAILED %0t %s", $time, msg);
      end
   endtask

   task automatic wrapUp();
      $display("Counts: %0d compares, %0d failed", compares, nFail);
      if (nFail == 0 && compares > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask

   // Waits settle on the falling edge, away from input changes
   task automatic waitMode(input logic [2:0] m, input int lim);
      n = 0;
      @(negedge clk);
      while (modeState !== m && n < lim) begin
         @(negedge clk);
         n++;
      end
   endtask

   task automatic cyc(input int k);
      repeat (k) @(negedge clk);
   endtask

   task automatic pulse(input int which);
      @(posedge clk);
      if (which == 0) wakeStatusRead <= 1'b1;
      else intStatusSecondRead <= 1'b1;
      @(posedge clk);
      wakeStatusRead <= 1'b0;
      intStatusSecondRead <= 1'b0;
   endtask

   task automatic sleepCmd();
      @(posedge clk);
      modeControl <= 3'h4;
      modeControlVerify <= 3'h4;
      modeWrite <= 1'b1;
      @(posedge clk);
      modeWrite <= 1'b0;
   endtask

   task automatic setOpt(input int i, input logic [2:0] opt);
      @(posedge clk);
      wakeInputControl[3*i +: 3] <= opt;
      wakeOptionWrite[i] <= 1'b1;
      @(posedge clk);
      wakeOptionWrite <= 3'h0;
   endtask

   task automatic setPin(input int i, input logic v);
      @(posedge clk);
      localWakeInputs[i] <= v;
   endtask

   ////////////////////////////////////////////////////////////////////////
   task automatic tPowerUp();
      cyc(1);
      check(8'(resetPinOe), 8'h1, "reset pin not driven");
      waitMode(3'h3, RST_C + 6);
      check(8'(modeState), 8'h3, "no normal request");
      waitMode(3'h1, 20);
      check(8'(modeState), 8'h1, "not normal");
   endtask

   task automatic tIrq();
      for (int i = 0; i < 6; i++) begin
         @(posedge clk);
         irqSources <= 8'(1 << i);
         irqMask <= 8'h00;
         cyc(3);
         check(8'(intN), 8'h1, "masked source interrupts");
         @(posedge clk);
         irqMask <= 8'(1 << i);
         cyc(3);
         check(8'(intN), 8'h0, "source without interrupt");
      end
      @(posedge clk);
      irqSources <= 8'h00;
   endtask

   // Option table: base level, active level, wake expected
   task automatic tLevels();
      logic [2:0] opts[4] = '{OPT_NONE, OPT_HIGH, OPT_LOW, OPT_CHANGE};
      logic b, a, e;
      irqMask <= 8'h40;
      for (int k = 0; k < 4; k++) begin
         b = (k == 2);
         a = !b;
         e = (k != 0);
         setPin(1, b);
         cyc(FI_C + 8);
         setOpt(1, opts[k]);
         pulse(0);
         setPin(1, a);
         setPin(1, b);
         cyc(FI_C + 8);
         check(8'(wakeInputStatus[1]), 8'h0, "glitch flagged");
         setPin(1, a);
         cyc(FI_C + 8);
         check(8'(wakeInputStatus[1]), 8'(e), "wake flag");
         check(8'(intN), 8'(!e), "local wake interrupt");
         check(8'(wakeInputLiveLevel[1]), 8'(a), "live level");
      end
      setOpt(1, OPT_NONE);
      pulse(0);
   endtask

   task automatic tRefuse();
      setOpt(0, OPT_HIGH);
      setPin(0, 1'b1);
      cyc(FI_C + 8);
      check(8'(wakeInputStatus[0]), 8'h1, "high level wake");
      sleepCmd();
      cyc(3);
      check(8'(modeState), 8'h1, "sleep with pending flag");
      setOpt(0, OPT_NONE);
      pulse(0);
      sleepCmd();
      waitMode(3'h4, 5);
      check(8'(mainRegulatorOn), 8'h0, "regulator on in sleep");
   endtask

   task automatic tSpiWake();
      @(posedge clk);
      mainRegulatorOff <= 1'b1;
      csFall <= 1'b1;
      @(posedge clk);
      csFall <= 1'b0;
      cyc(6);
      check(8'(modeState == 3'h4), 8'h0, "cs fall no wake");
      check(8'(spiWakeFlag), 8'h1, "spi wake flag");
      @(posedge clk);
      mainRegulatorOff <= 1'b0;
      waitMode(3'h1, RST_C + 40);
      pulse(1);
      cyc(1);
      check(8'(spiWakeFlag), 8'h0, "spi flag not cleared");
   endtask

   // Every period code; no config, so back to sleep
   task automatic tForced();
      @(posedge clk);
      autoCfg <= 1'b0;
      timedForcedWake <= 1'b1;
      inputsOnSwitchedSupply <= 1'b1;
      cyclicTimingControl <= 3'h0;
      setOpt(2, OPT_HIGH);
      sleepCmd();
      for (int k = 0; k < 8; k++) begin
         waitMode(3'h4, TO_C + 10);
         check(8'(modeState), 8'h4, "no return to sleep");
         waitMode(3'h0, PER[k] * MS_C + 20);
         check(8'(n >= PER[k] * MS_C - 4 && n <= PER[k] * MS_C + 4), 8'h1,
            "forced wake period");
         check(8'(mainRegulatorOn && resetPinOe), 8'h1, "wake reset");
         waitMode(3'h3, RST_C + 10);
         @(posedge clk);
         cyclicTimingControl <= 3'(k + 1);
      end
      @(posedge clk);
      timedForcedWake <= 1'b0;
      waitMode(3'h4, TO_C + 10);
      setPin(2, 1'b1);
      cyc(FI_C + 10);
      check(8'(modeState), 8'h4, "wake with supply off");
      @(posedge clk);
      inputsOnSwitchedSupply <= 1'b0;
      autoCfg <= 1'b1;
      cyc(FI_C + 10);
      check(8'(wakeInputStatus[2]), 8'h1, "sleep wake flag");
      check(8'(modeState == 3'h4), 8'h0, "still asleep");
      waitMode(3'h1, RST_C + 40);
      check(8'(modeState), 8'h1, "not back to normal");
   endtask

   task automatic tResetPin();
      @(posedge clk);
      pullLow <= 1'b1;
      cyc(5);
      @(posedge clk);
      pullLow <= 1'b0;
      waitMode(3'h3, 10);
      check(8'(modeState), 8'h3, "pin release no request");
   endtask

   ////////////////////////////////////////////////////////////////////////
   // Main sequence
   initial begin
      nFail = 0;
      compares = 0;
      {resetn, timedForcedWake, cyclicSenseEn, switchedOnReq} = 4'h0;
      {inputsOnSwitchedSupply, wakeStatusRead, intStatusSecondRead} = 3'h0;
      {cyclicTimingControl, wakeOptionWrite, modeControl} = 9'h000;
      {modeControlVerify, localWakeInputs, wakeInputControl} = 15'h0000;
      {irqSources, irqMask, modeWrite, mainRegulatorOff} = 18'h00000;
      {pullLow, csFall} = 2'h0;
      autoCfg = 1'b1;
      repeat (12) @(posedge clk);
      resetn <= 1'b1;
      tPowerUp();
      tIrq();
      tLevels();
      tRefuse();
      tSpiWake();
      tForced();
      tResetPin();
      wrapUp();
   end
endmodule
